/* pkg/bsc_pkg.sv */
package bsc_pkg;

  // ----------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_RSVD_ZERO      = 16'h0000;
  localparam logic [15:0] REG_FW_VERSION     = 16'h0001;
  localparam logic [15:0] REG_FW_REVISION    = 16'h0002;
  localparam logic [15:0] REG_FW_CHECK_HIGH  = 16'h0003;
  localparam logic [15:0] REG_FW_CHECK_LOW   = 16'h0004;
  localparam logic [15:0] REG_UNIT_ENABLE    = 16'h0005;
  localparam logic [15:0] REG_PREPURGE       = 16'h0006;
  localparam logic [15:0] REG_IGNITION       = 16'h0007;
  localparam logic [15:0] REG_INTERIGN_PURGE = 16'h0008;
  localparam logic [15:0] REG_WAIT           = 16'h0009;
  localparam logic [15:0] REG_IGN_RETRY      = 16'h000A;
  localparam logic [15:0] REG_WAIT_RETRY     = 16'h000B;
  localparam logic [15:0] REG_FLAME_PROVEN   = 16'h000C;
  localparam logic [15:0] REG_PILOT_REQ_EN   = 16'h000D;
  localparam logic [15:0] REG_THERMO_LIMIT   = 16'h000E;
  localparam logic [15:0] REG_RSVD_LAST      = 16'h0013;
  localparam logic [15:0] REG_STOP_CMD       = 16'h01F4;

  localparam int CFG_FIRST = 5;
  localparam int CFG_LAST  = 14;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [15:0] STOP_PASSCODE  = 16'h5D6D;
  localparam logic [7:0]  NODE_MIN       = 8'h01;
  localparam logic [7:0]  NODE_MAX       = 8'hF7;
  localparam logic [7:0]  NODE_RST       = 8'h01;
  localparam logic [7:0]  EXC_NONE       = 8'h00;
  localparam logic [7:0]  EXC_ILL_ADDR   = 8'h02;
  localparam logic [7:0]  EXC_ILL_VALUE  = 8'h03;

  localparam int  CLK_HZ         = 125_000_000;
  localparam int  SECOND_S       = 1;
  localparam int  CYC_PER_SECOND = CLK_HZ * SECOND_S;

  // ----------------------------------------------------------------
  // Per-register reset value and legal range
  // ----------------------------------------------------------------
  function automatic logic [15:0] cfg_rst(input int idx);
    unique case (idx)
      6:       cfg_rst = 16'h0005;
      7:       cfg_rst = 16'h001E;
      8:       cfg_rst = 16'h000A;
      10, 11:  cfg_rst = 16'h0002;
      12:      cfg_rst = 16'h0003;
      14:      cfg_rst = 16'h0640;
      default: cfg_rst = 16'h0000;
    endcase
  endfunction : cfg_rst

  function automatic logic [15:0] cfg_min(input int idx);
    unique case (idx)
      7:       cfg_min = 16'h0001;
      14:      cfg_min = 16'h0064;
      default: cfg_min = 16'h0000;
    endcase
  endfunction : cfg_min

  function automatic logic [15:0] cfg_max(input int idx);
    unique case (idx)
      6:       cfg_max = 16'h0258;
      7:       cfg_max = 16'h003C;
      8:       cfg_max = 16'h000A;
      9:       cfg_max = 16'h0708;
      10, 11:  cfg_max = 16'h0003;
      12:      cfg_max = 16'h0005;
      14:      cfg_max = 16'h099C;
      default: cfg_max = 16'h0001;
    endcase
  endfunction : cfg_max

endpackage : bsc_pkg

/* rtl/bsc_regs.sv */
module bsc_regs
  import bsc_pkg::*;
#(
  parameter logic [15:0] FW_VERSION    = 16'h0100,  // Arbitrary value
  parameter logic [15:0] FW_REVISION   = 16'h0001,  // Arbitrary value
  parameter logic [15:0] FW_CHECK_HIGH = 16'h0000,
  parameter logic [15:0] FW_CHECK_LOW  = 16'h0000,
  parameter int          CYC_SECOND    = CYC_PER_SECOND
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  NODE_ADDR_CFG,
  input  wire logic        REQ_VALID,
  input  wire logic [7:0]  REQ_NODE,
  input  wire logic        REQ_WRITE,
  input  wire logic [15:0] REQ_ADDR,
  input  wire logic [15:0] REQ_WDATA,
  output logic             RSP_VALID,
  output logic [15:0]      RSP_RDATA,
  output logic [7:0]       RSP_EXC,
  output logic             STOP_CMD,
  input  wire logic        FLAME_DET,
  output logic             PILOT_PROVEN,
  output logic             UNIT_ENABLE,
  output logic [15:0]      PREPURGE_SEC,
  output logic [15:0]      IGNITION_SEC,
  output logic [15:0]      PURGE_SEC,
  output logic [15:0]      WAIT_SEC,
  output logic [15:0]      IGN_RETRY,
  output logic [15:0]      WAIT_RETRY,
  output logic [15:0]      FLAME_PROVEN_SEC,
  output logic             PILOT_REQ_EN,
  output logic [15:0]      THERMO_LIMIT
);

  // ----------------------------------------------------------------
  // Node address
  // ----------------------------------------------------------------
  logic [7:0] node_addr_r;
  logic [7:0] node_addr_nxt;
  wire        node_cfg_ok = (NODE_ADDR_CFG >= NODE_MIN) && (NODE_ADDR_CFG <= NODE_MAX);

  // Out-of-range setting falls back to default rather than going deaf
  assign node_addr_nxt = node_cfg_ok ? NODE_ADDR_CFG : NODE_RST;

  always_ff @(posedge CLK) begin
    if (!RST_N) node_addr_r <= NODE_RST;
    else        node_addr_r <= node_addr_nxt;
  end

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  function automatic logic value_ok(input logic [15:0] addr, input logic [15:0] d);
    logic ok;
    ok = 1'b0;
    if (addr == REG_THERMO_LIMIT)
      ok = ($signed(d) >= $signed(cfg_min(CFG_LAST))) &&
           ($signed(d) <= $signed(cfg_max(CFG_LAST)));
    else if (addr >= 16'(CFG_FIRST) && addr <= 16'(CFG_LAST))
      ok = (d >= cfg_min(int'(addr))) && (d <= cfg_max(int'(addr)));
    return ok;
  endfunction : value_ok

  wire req_hit  = REQ_VALID && (REQ_NODE == node_addr_r);
  wire is_cfg   = (REQ_ADDR >= 16'(CFG_FIRST)) && (REQ_ADDR <= 16'(CFG_LAST));
  wire is_stop  = (REQ_ADDR == REG_STOP_CMD);
  wire is_read  = (REQ_ADDR <= REG_RSVD_LAST);
  wire wr_hit   = req_hit && REQ_WRITE;
  wire val_ok   = value_ok(REQ_ADDR, REQ_WDATA);
  wire cfg_wr   = wr_hit && is_cfg && val_ok;
  wire stop_ok  = wr_hit && is_stop && (REQ_WDATA == STOP_PASSCODE);

  // ----------------------------------------------------------------
  // Configuration words
  // ----------------------------------------------------------------
  logic [15:0] cfg_r [CFG_FIRST:CFG_LAST];

  // Bad values are refused whole; the old setting stays in force
  for (genvar i = CFG_FIRST; i <= CFG_LAST; i++) begin : g_cfg
    always_ff @(posedge CLK) begin
      if (!RST_N)
        cfg_r[i] <= cfg_rst(i);
      else if (cfg_wr && REQ_ADDR == 16'(i))
        cfg_r[i] <= REQ_WDATA;
    end
  end

  assign UNIT_ENABLE      = cfg_r[5][0];
  assign PREPURGE_SEC     = cfg_r[6];
  assign IGNITION_SEC     = cfg_r[7];
  assign PURGE_SEC        = cfg_r[8];
  assign WAIT_SEC         = cfg_r[9];
  assign IGN_RETRY        = cfg_r[10];
  assign WAIT_RETRY       = cfg_r[11];
  assign FLAME_PROVEN_SEC = cfg_r[12];
  assign PILOT_REQ_EN     = cfg_r[13][0];
  assign THERMO_LIMIT     = cfg_r[14];

  // ----------------------------------------------------------------
  // Read data and answer
  // ----------------------------------------------------------------
  logic [15:0] rd_word;
  logic [7:0]  exc_nxt;

  always_comb begin
    rd_word = 16'h0000;
    if (REQ_ADDR == REG_FW_VERSION)          rd_word = FW_VERSION;
    else if (REQ_ADDR == REG_FW_REVISION)    rd_word = FW_REVISION;
    else if (REQ_ADDR == REG_FW_CHECK_HIGH)  rd_word = FW_CHECK_HIGH;
    else if (REQ_ADDR == REG_FW_CHECK_LOW)   rd_word = FW_CHECK_LOW;
    else if (is_cfg)                         rd_word = cfg_r[int'(REQ_ADDR)];
  end

  // Read-only words answer a write with an address error, never a store
  always_comb begin
    exc_nxt = EXC_NONE;
    if (REQ_WRITE) begin
      if (!is_cfg && !is_stop)                      exc_nxt = EXC_ILL_ADDR;
      else if (is_cfg && !val_ok)                   exc_nxt = EXC_ILL_VALUE;
      else if (is_stop && REQ_WDATA != STOP_PASSCODE) exc_nxt = EXC_ILL_VALUE;
    end else if (!is_read) begin
      exc_nxt = EXC_ILL_ADDR;
    end
  end

  logic        rsp_valid_r;
  logic [15:0] rsp_rdata_r;
  logic [7:0]  rsp_exc_r;
  logic        stop_r;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= 16'h0000;
      rsp_exc_r   <= EXC_NONE;
      stop_r      <= 1'b0;
    end else begin
      rsp_valid_r <= req_hit;
      stop_r      <= stop_ok;
      if (req_hit) begin
        rsp_rdata_r <= (REQ_WRITE || exc_nxt != EXC_NONE) ? 16'h0000 : rd_word;
        rsp_exc_r   <= exc_nxt;
      end
    end
  end

  assign RSP_VALID = rsp_valid_r;
  assign RSP_RDATA = rsp_rdata_r;
  assign RSP_EXC   = rsp_exc_r;
  assign STOP_CMD  = stop_r;

  // ----------------------------------------------------------------
  // Pilot flame proving timer
  // ----------------------------------------------------------------
  localparam int CW = $clog2(CYC_SECOND + 1);

  logic [CW-1:0] cyc_r;
  logic [2:0]    secs_r;
  logic          proven_r;
  wire           sec_tick = (cyc_r == CW'(CYC_SECOND - 1));
  wire           secs_met = {13'h0000, secs_r} >= cfg_r[12];

  // Any dropout of the flame restarts the whole proving interval
  always_ff @(posedge CLK) begin
    if (!RST_N || !FLAME_DET) begin
      cyc_r    <= '0;
      secs_r   <= 3'h0;
      proven_r <= 1'b0;
    end else begin
      cyc_r    <= sec_tick ? '0 : cyc_r + CW'(1);
      if (sec_tick && secs_r != 3'h7) secs_r <= secs_r + 3'h1;
      proven_r <= secs_met;
    end
  end

  assign PILOT_PROVEN = proven_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_read_of(logic [15:0] a);
    REQ_VALID && !REQ_WRITE && REQ_NODE == node_addr_r && REQ_ADDR == a;
  endsequence

  sequence s_bad_cfg_write;
    wr_hit && is_cfg && !val_ok;
  endsequence

  a_version_read: assert property (@(posedge CLK) disable iff (!RST_N)
    s_read_of(REG_FW_VERSION) |=> RSP_VALID && RSP_RDATA == FW_VERSION)
    else $error("version word read wrong");

  a_revision_read: assert property (@(posedge CLK) disable iff (!RST_N)
    s_read_of(REG_FW_REVISION) |=> RSP_VALID && RSP_RDATA == FW_REVISION)
    else $error("revision word read wrong");

  a_prepurge_range: assert property (@(posedge CLK) disable iff (!RST_N)
    PREPURGE_SEC <= 16'h0258)
    else $error("prepurge seconds out of range");

  a_ignition_range: assert property (@(posedge CLK) disable iff (!RST_N)
    IGNITION_SEC >= 16'h0001 && IGNITION_SEC <= 16'h003C)
    else $error("ignition seconds out of range");

  a_purge_range: assert property (@(posedge CLK) disable iff (!RST_N)
    PURGE_SEC <= 16'h000A)
    else $error("purge seconds out of range");

  a_wait_range: assert property (@(posedge CLK) disable iff (!RST_N)
    WAIT_SEC <= 16'h0708)
    else $error("wait seconds out of range");

  a_pilot_dropout: assert property (@(posedge CLK) disable iff (!RST_N)
    !FLAME_DET |=> !PILOT_PROVEN)
    else $error("pilot proven without flame");

  a_pilot_needs_flame: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(PILOT_PROVEN) |-> $past(FLAME_DET) && $past(secs_met))
    else $error("pilot proven too early");

  a_temp_range: assert property (@(posedge CLK) disable iff (!RST_N)
    $signed(THERMO_LIMIT) >= 16'sd100 && $signed(THERMO_LIMIT) <= 16'sd2460)
    else $error("temperature limit out of range");

  a_enable_bit: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_hit && REQ_ADDR == REG_UNIT_ENABLE && REQ_WDATA == 16'h0001 |=> UNIT_ENABLE)
    else $error("unit enable not set");

  a_bad_value_kept: assert property (@(posedge CLK) disable iff (!RST_N)
    s_bad_cfg_write |=> RSP_EXC == EXC_ILL_VALUE && $stable(IGN_RETRY)
      && $stable(WAIT_RETRY) && $stable(PREPURGE_SEC) && $stable(IGNITION_SEC)
      && $stable(PURGE_SEC) && $stable(WAIT_SEC) && $stable(THERMO_LIMIT))
    else $error("bad value not refused");

  a_unused_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    s_read_of(REG_RSVD_ZERO) |=> RSP_RDATA == 16'h0000 && RSP_EXC == EXC_NONE)
    else $error("unused word not zero");

  a_stop_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
    stop_ok ##1 !stop_ok |-> STOP_CMD ##1 !STOP_CMD)
    else $error("stop pulse wrong");

  a_foreign_node: assert property (@(posedge CLK) disable iff (!RST_N)
    REQ_VALID && REQ_NODE != node_addr_r |=> !RSP_VALID && !STOP_CMD)
    else $error("answered foreign node");

  // ----------------------------------------------------------------
  // Reset values, ranges and access checks
  // ----------------------------------------------------------------
  sequence s_good_cfg_write;
    wr_hit && is_cfg && val_ok;
  endsequence

  sequence s_reset_done;
    $rose(RST_N);
  endsequence

  a_timer_reset: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reset_done |-> PREPURGE_SEC == 16'h0005 && IGNITION_SEC == 16'h001E
      && PURGE_SEC == 16'h000A && WAIT_SEC == 16'h0000)
    else $error("timer words not at reset value");

  a_retry_reset: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reset_done |-> IGN_RETRY == 16'h0002 && WAIT_RETRY == 16'h0002)
    else $error("retry counts not at reset value");

  a_pilot_reset: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reset_done |-> FLAME_PROVEN_SEC == 16'h0003 && !PILOT_PROVEN)
    else $error("pilot timer not at reset value");

  a_limit_reset: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reset_done |-> THERMO_LIMIT == 16'h0640)
    else $error("temperature limit not at reset value");

  a_enable_reset: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reset_done |-> !UNIT_ENABLE && !PILOT_REQ_EN && !STOP_CMD && !RSP_VALID)
    else $error("enables or answer not idle after reset");

  a_retry_range: assert property (@(posedge CLK) disable iff (!RST_N)
    IGN_RETRY <= 16'h0003 && WAIT_RETRY <= 16'h0003)
    else $error("retry count out of range");

  a_enable_range: assert property (@(posedge CLK) disable iff (!RST_N)
    cfg_r[5] <= 16'h0001 && cfg_r[13] <= 16'h0001)
    else $error("enable word out of range");

  a_prepurge_write: assert property (@(posedge CLK) disable iff (!RST_N)
    s_good_cfg_write ##0 REQ_ADDR == REG_PREPURGE |=> PREPURGE_SEC == $past(REQ_WDATA))
    else $error("prepurge write not stored");

  a_ignition_write: assert property (@(posedge CLK) disable iff (!RST_N)
    s_good_cfg_write ##0 REQ_ADDR == REG_IGNITION |=> IGNITION_SEC == $past(REQ_WDATA))
    else $error("ignition write not stored");

  a_limit_write: assert property (@(posedge CLK) disable iff (!RST_N)
    s_good_cfg_write ##0 REQ_ADDR == REG_THERMO_LIMIT |=> THERMO_LIMIT == $past(REQ_WDATA))
    else $error("temperature limit write not stored");

  a_readonly_write: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_hit && (REQ_ADDR == REG_FW_VERSION || REQ_ADDR == REG_FW_REVISION)
      |=> RSP_VALID && RSP_EXC == EXC_ILL_ADDR)
    else $error("write to firmware word not refused");

  a_unused_write: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_hit && REQ_ADDR > REG_THERMO_LIMIT && REQ_ADDR <= REG_RSVD_LAST
      |=> RSP_EXC == EXC_ILL_ADDR)
    else $error("write to unused word not refused");

  a_read_above: assert property (@(posedge CLK) disable iff (!RST_N)
    req_hit && !REQ_WRITE && REQ_ADDR > REG_RSVD_LAST
      |=> RSP_EXC == EXC_ILL_ADDR && RSP_RDATA == 16'h0000)
    else $error("read of write-only number not refused");

  a_stop_bad_code: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_hit && is_stop && REQ_WDATA != STOP_PASSCODE |=> !STOP_CMD && RSP_EXC == EXC_ILL_VALUE)
    else $error("stop taken on wrong code");

  a_answer_next: assert property (@(posedge CLK) disable iff (!RST_N)
    req_hit |=> RSP_VALID)
    else $error("own node request not answered");

  a_node_follows: assert property (@(posedge CLK) disable iff (!RST_N)
    $past(RST_N) && $past(node_cfg_ok) |-> node_addr_r == $past(NODE_ADDR_CFG))
    else $error("node address not taken");

  a_node_fallback: assert property (@(posedge CLK) disable iff (!RST_N)
    $past(RST_N) && !$past(node_cfg_ok) |-> node_addr_r == NODE_RST)
    else $error("bad node address not replaced");

  a_pilot_zero_wait: assert property (@(posedge CLK) disable iff (!RST_N)
    FLAME_DET && FLAME_PROVEN_SEC == 16'h0000 |=> PILOT_PROVEN)
    else $error("pilot not proven at zero wait");

  a_pilot_holds: assert property (@(posedge CLK) disable iff (!RST_N)
    PILOT_PROVEN && FLAME_DET && $stable(FLAME_PROVEN_SEC) |=> PILOT_PROVEN)
    else $error("pilot proven dropped with flame present");

  a_prepurge_read: assert property (@(posedge CLK) disable iff (!RST_N)
    s_read_of(REG_PREPURGE) |=> RSP_EXC == EXC_NONE && RSP_RDATA == $past(PREPURGE_SEC))
    else $error("prepurge read wrong");

endmodule : bsc_regs

/* verif/bsc_master.sv */
// ----------------------------------------------------------------
// Bus master model: one request, answer awaited a few cycles
// ----------------------------------------------------------------
module bsc_master (
  input  wire logic        CLK,
  input  wire logic        RSP_VALID,
  input  wire logic [15:0] RSP_RDATA,
  input  wire logic [7:0]  RSP_EXC,
  output logic             REQ_VALID,
  output logic [7:0]       REQ_NODE,
  output logic             REQ_WRITE,
  output logic [15:0]      REQ_ADDR,
  output logic [15:0]      REQ_WDATA
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    REQ_VALID = 1'b0;
    REQ_NODE  = 8'h01;
    REQ_WRITE = 1'b0;
    REQ_ADDR  = 16'h0000;
    REQ_WDATA = 16'h0000;
  end

  task automatic xfer(input logic [7:0] node, input logic wr, input logic [15:0] addr,
                      input logic [15:0] wdata, output logic got,
                      output logic [15:0] rdata, output logic [7:0] exc);
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    REQ_NODE  <= node;
    REQ_WRITE <= wr;
    REQ_ADDR  <= addr;
    REQ_WDATA <= wdata;
    @(posedge CLK);
    // Released write, address and data lines show inverted values so stale values never match
    REQ_VALID <= 1'b0;
    REQ_WRITE <= ~wr;
    REQ_ADDR  <= ~addr;
    REQ_WDATA <= ~wdata;
    got   = 1'b0;
    rdata = 16'h0000;
    exc   = 8'h00;
    for (int i = 0; i < 3 && got !== 1'b1; i++) begin
      #1;
      if (RSP_VALID === 1'b1) begin
        got   = 1'b1;
        rdata = RSP_RDATA;
        exc   = RSP_EXC;
      end else begin
        @(posedge CLK);
      end
    end
  endtask : xfer
endmodule : bsc_master

/* verif/bsc_regs_tb.sv */
module bsc_regs_tb;
  import bsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Arbitrary identification values
  localparam logic [15:0] FWV = 16'h3C5A;
  localparam logic [15:0] FWR = 16'h0007;
  localparam logic [15:0] FCH = 16'hBEEF;
  localparam logic [15:0] FCL = 16'h1234;

  logic        CLK, RST_N, REQ_VALID, REQ_WRITE, RSP_VALID, STOP_CMD, FLAME_DET;
  logic        PILOT_PROVEN, UNIT_ENABLE, PILOT_REQ_EN;
  logic [7:0]  NODE_ADDR_CFG, REQ_NODE, RSP_EXC;
  logic [15:0] REQ_ADDR, REQ_WDATA, RSP_RDATA, PREPURGE_SEC, IGNITION_SEC, PURGE_SEC;
  logic [15:0] WAIT_SEC, IGN_RETRY, WAIT_RETRY, FLAME_PROVEN_SEC, THERMO_LIMIT;
  int          num_errors, n_tests;
  logic [15:0] rst_v [5:14] = '{16'h0000, 16'h0005, 16'h001E, 16'h000A, 16'h0000,
                                16'h0002, 16'h0002, 16'h0003, 16'h0000, 16'h0640};
  logic [15:0] lo_v  [5:14] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000,
                                16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064};
  logic [15:0] hi_v  [5:14] = '{16'h0001, 16'h0258, 16'h003C, 16'h000A, 16'h0708,
                                16'h0003, 16'h0003, 16'h0005, 16'h0001, 16'h099C};
  logic [7:0]  cfg_v [4] = '{8'h05, 8'hF7, 8'h00, 8'hF8};
  logic [7:0]  nod_v [4] = '{8'h05, 8'hF7, 8'h01, 8'h01};

  always #4 CLK = ~CLK;

  bsc_master i_bsc_master (.CLK(CLK), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
    .RSP_EXC(RSP_EXC), .REQ_VALID(REQ_VALID), .REQ_NODE(REQ_NODE), .REQ_WRITE(REQ_WRITE),
    .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA));

  bsc_regs #(.FW_VERSION(FWV), .FW_REVISION(FWR), .FW_CHECK_HIGH(FCH), .FW_CHECK_LOW(FCL),
    .CYC_SECOND(10)) i_bsc_regs (.CLK(CLK), .RST_N(RST_N), .NODE_ADDR_CFG(NODE_ADDR_CFG),
    .REQ_VALID(REQ_VALID), .REQ_NODE(REQ_NODE), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .RSP_EXC(RSP_EXC),
    .STOP_CMD(STOP_CMD), .FLAME_DET(FLAME_DET), .PILOT_PROVEN(PILOT_PROVEN),
    .UNIT_ENABLE(UNIT_ENABLE), .PREPURGE_SEC(PREPURGE_SEC), .IGNITION_SEC(IGNITION_SEC),
    .PURGE_SEC(PURGE_SEC), .WAIT_SEC(WAIT_SEC), .IGN_RETRY(IGN_RETRY),
    .WAIT_RETRY(WAIT_RETRY), .FLAME_PROVEN_SEC(FLAME_PROVEN_SEC),
    .PILOT_REQ_EN(PILOT_REQ_EN), .THERMO_LIMIT(THERMO_LIMIT));

  // ----------------------------------------------------------------
  // Check and access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic acc(input logic [7:0] node, input logic wr, input logic [15:0] a,
                     input logic [15:0] d, input logic eg, input logic [15:0] erd,
                     input logic [7:0] eex);
    logic        g;
    logic [15:0] rd;
    logic [7:0]  ex;
    i_bsc_master.xfer(node, wr, a, d, g, rd, ex);
    chk({15'h0000, g}, {15'h0000, eg}, "answer");
    if (g === 1'b1) begin
      chk(rd, erd, "rdata");
      chk({8'h00, ex}, {8'h00, eex}, "exception");
    end
  endtask : acc

  // Timer measured from the edge that raises the flame input
  task automatic flame(input int n);
    int c;
    c = 0;
    @(posedge CLK);
    FLAME_DET <= 1'b1;
    while (PILOT_PROVEN !== 1'b1 && c < 200) begin
      @(posedge CLK);
      #1;
      c++;
    end
    if (c >= 200) begin
      num_errors++;
      stop_test();
    end
    chk(c[15:0], 16'(n * 10 + 1), "flame delay");
    @(posedge CLK);
    FLAME_DET <= 1'b0;
    @(posedge CLK);
    #1;
    chk({15'h0000, PILOT_PROVEN}, 16'h0000, "flame drop");
  endtask : flame

  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    RST_N = 1'b0;
    NODE_ADDR_CFG = 8'h01;
    FLAME_DET = 1'b0;
    num_errors = 0;
    n_tests = 0;
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    acc(8'h01, 1'b0, 16'h0001, 16'h0000, 1'b1, FWV, EXC_NONE);
    acc(8'h01, 1'b1, 16'h0001, 16'h5555, 1'b1, 16'h0000, EXC_ILL_ADDR);
    acc(8'h01, 1'b0, 16'h0001, 16'h0000, 1'b1, FWV, EXC_NONE);
    acc(8'h01, 1'b1, 16'h0002, 16'h5555, 1'b1, 16'h0000, EXC_ILL_ADDR);
    acc(8'h01, 1'b0, 16'h0002, 16'h0000, 1'b1, FWR, EXC_NONE);
    acc(8'h01, 1'b0, 16'h0003, 16'h0000, 1'b1, FCH, EXC_NONE);
    acc(8'h01, 1'b0, 16'h0004, 16'h0000, 1'b1, FCL, EXC_NONE);
    for (int i = 15; i <= 20; i++) begin
      acc(8'h01, 1'b0, (i == 20) ? 16'h0000 : i[15:0], 16'h0000, 1'b1, 16'h0000, EXC_NONE);
      acc(8'h01, 1'b1, i[15:0], 16'h0001, 1'b1, 16'h0000, EXC_ILL_ADDR);
    end
    for (int i = 5; i <= 14; i++) begin
      acc(8'h01, 1'b0, i[15:0], 16'h0000, 1'b1, rst_v[i], EXC_NONE);
      acc(8'h01, 1'b1, i[15:0], lo_v[i], 1'b1, 16'h0000, EXC_NONE);
      if (lo_v[i] != 16'h0000) begin
        acc(8'h01, 1'b1, i[15:0], lo_v[i] - 16'h0001, 1'b1, 16'h0000, EXC_ILL_VALUE);
      end
      acc(8'h01, 1'b1, i[15:0], hi_v[i] + 16'h0001, 1'b1, 16'h0000, EXC_ILL_VALUE);
      acc(8'h01, 1'b1, i[15:0], hi_v[i], 1'b1, 16'h0000, EXC_NONE);
      acc(8'h01, 1'b0, i[15:0], 16'h0000, 1'b1, hi_v[i], EXC_NONE);
    end
    acc(8'h01, 1'b1, 16'h000E, 16'hFFFF, 1'b1, 16'h0000, EXC_ILL_VALUE);
    chk({14'h0000, UNIT_ENABLE, PILOT_REQ_EN}, 16'h0003, "enables");
    chk(PREPURGE_SEC, 16'h0258, "prepurge out");
    chk(THERMO_LIMIT, 16'h099C, "limit out");
    chk(WAIT_SEC, 16'h0708, "wait out");
    chk(IGNITION_SEC, 16'h003C, "ignition out");
    chk(PURGE_SEC, 16'h000A, "purge out");
    chk(IGN_RETRY, 16'h0003, "ign retry out");
    chk(WAIT_RETRY, 16'h0003, "wait retry out");
    chk(FLAME_PROVEN_SEC, 16'h0005, "proven out");
    acc(8'h01, 1'b0, 16'h01F4, 16'h0000, 1'b1, 16'h0000, EXC_ILL_ADDR);
    acc(8'h01, 1'b1, 16'h01F4, 16'h5D6C, 1'b1, 16'h0000, EXC_ILL_VALUE);
    chk({15'h0000, STOP_CMD}, 16'h0000, "stop on bad code");
    acc(8'h01, 1'b1, 16'h01F4, 16'd23917, 1'b1, 16'h0000, EXC_NONE);
    chk({15'h0000, STOP_CMD}, 16'h0001, "stop pulse");
    @(posedge CLK);
    #1;
    chk({15'h0000, STOP_CMD}, 16'h0000, "stop pulse end");
    acc(8'h02, 1'b0, 16'h0006, 16'h0000, 1'b0, 16'h0000, EXC_NONE);
    for (int k = 0; k < 4; k++) begin
      @(posedge CLK);
      NODE_ADDR_CFG <= cfg_v[k];
      repeat (2) @(posedge CLK);
      acc(nod_v[k], 1'b0, 16'h0006, 16'h0000, 1'b1, 16'h0258, EXC_NONE);
      acc(nod_v[k] + 8'h01, 1'b0, 16'h0006, 16'h0000, 1'b0, 16'h0000, EXC_NONE);
    end
    flame(5);
    acc(8'h01, 1'b1, 16'h000C, 16'h0000, 1'b1, 16'h0000, EXC_NONE);
    flame(0);
    // Second reset in mid-run must bring the defaults back
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    acc(8'h01, 1'b0, 16'h0006, 16'h0000, 1'b1, 16'h0005, EXC_NONE);
    acc(8'h01, 1'b0, 16'h000C, 16'h0000, 1'b1, 16'h0003, EXC_NONE);
    acc(8'h01, 1'b0, 16'h000E, 16'h0000, 1'b1, 16'h0640, EXC_NONE);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    stop_test();
  end
endmodule : bsc_regs_tb
